// File: dsr_pkg.sv
// Purpose: Shared constants and types for the differential converter serial readout.
// Assumes: The host end runs on i_clk and makes the serial clock; the device runs on that clock.
// Notes: Rule summary follows.
// Operation
// - Select low starts a session and conversion.
// - Select high aborts conversion, enters standby.
// - Host raises select after every conversion.
// - Data output changes only on falling edges.
// - Clock edges start conversion, one bit each.
// - Acquisition lasts one and a half clocks.
// - Thirteen conversion clocks follow acquisition immediately.
// - Result spans 8192 codes, bipolar range.
// - Extremes are 0x1000 and 0x0fff.
// - Smallest positive input yields code 0x0001.
// - Sign bit first, most significant first.
// - Result is 13-bit two's complement.
// - Host finishes all bits within 1.2 ms.
// - Device tolerates any duty cycle, spacing.
package dsr_pkg;
  localparam int unsigned RES_BITS = 13;
  localparam int unsigned CODE_COUNT = 8192;
  localparam logic [12:0] CODE_MOST_NEG = 13'h1000;
  localparam logic [12:0] CODE_MOST_POS = 13'h0fff;
  localparam logic [12:0] CODE_ONE = 13'h0001;
  // Acquisition: falling edge count before the first result bit (1.5 clocks).
  localparam logic [3:0] ACQ_FALLS = 4'h2;
  localparam logic [3:0] LAST_BIT = 4'hc;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MAX_CONV_US = 1200;
  localparam int unsigned MAX_CONV_CYC = MAX_CONV_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DIV_HALF = 4;
  localparam logic [3:0] ZERO4 = 4'h0;
  typedef logic [12:0] dsr_code_t;
  // Saturate a signed sample into the legal code range.
  function automatic dsr_code_t dsr_clamp(input logic signed [15:0] v);
    if (v > 16'sh0fff) begin
      return CODE_MOST_POS;
    end else if (v < -16'sh1000) begin
      return CODE_MOST_NEG;
    end else begin
      return v[12:0];
    end
  endfunction : dsr_clamp
endpackage : dsr_pkg

// File: dsr_link_if.sv
// Purpose: Serial link between host and converter.
// Assumes: Device drives the data pin only while selected.
// Notes: Data pin enable is low while driving.
interface dsr_link_if;
  logic sclk;
  logic select_shutdown_n;
  logic sdata;
  logic sdata_oe_n;
  wire sdata_wire;
  // Released pin is modelled as a weak high level.
  assign sdata_wire = sdata_oe_n ? 1'b1 : sdata;
  modport device (input sclk, input select_shutdown_n, output sdata, output sdata_oe_n);
  modport host (output sclk, output select_shutdown_n, input sdata_wire);
endinterface : dsr_link_if

// File: dsr_host.sv
// Purpose: Host end: makes the serial clock, runs one session per request, returns codes.
// Assumes: i_clk at 100 MHz; result consumer may stall via i_res_ready.
// Notes: Two-entry skid buffer holds results so a stall loses no word.
module dsr_host
  import dsr_pkg::*;
#(
  parameter int unsigned HALF_DIV = dsr_pkg::DIV_HALF,
  parameter int unsigned MAX_CYC = dsr_pkg::MAX_CONV_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  output logic o_busy,
  output logic o_timeout,
  output logic [12:0] o_res_data,
  output logic o_res_valid,
  input wire logic i_res_ready,
  dsr_link_if.host link
);
  import dsr_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} dsr_hst_t;
  dsr_hst_t state;
  logic [7:0] div;
  logic sclk;
  logic sel_n;
  logic [4:0] falls;
  logic [12:0] shreg;
  logic [31:0] tcnt;
  logic d_s1, d_s2;
  logic [12:0] buf_d [2];
  logic [1:0] cnt;
  logic rd_ptr, wr_ptr;
  wire div_tick = (div == 8'(HALF_DIV - 1));
  wire rise = div_tick && !sclk && state == ST_RUN;
  wire fall = div_tick && sclk && state == ST_RUN;
  wire buf_ready = (cnt != 2'h2);
  wire push = fall && (falls == 5'(RES_BITS + 1));
  wire pop = (cnt != 2'h0) && i_res_ready;
  // Pin data passes two flops before use.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      d_s1 <= 1'b0;
      d_s2 <= 1'b0;
    end else begin
      d_s1 <= link.sdata_wire;
      d_s2 <= d_s1;
    end
  end
  // Session sequencer; a session starts only when the buffer has room.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      div <= 8'h00;
      sclk <= 1'b0;
      sel_n <= 1'b1;
      falls <= 5'h00;
      shreg <= 13'h0000;
      tcnt <= 32'h0;
      o_timeout <= 1'b0;
    end else begin
      div <= div_tick ? 8'h00 : div + 8'h01;
      unique case (state)
        ST_IDLE: begin
          if (i_start && buf_ready && div_tick) begin
            sel_n <= 1'b0;
            falls <= 5'h00;
            tcnt <= 32'h0;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          tcnt <= tcnt + 32'h1;
          if (tcnt > MAX_CYC) o_timeout <= 1'b1;
          if (div_tick) sclk <= !sclk;
          if (rise && falls >= 5'(ACQ_FALLS)) shreg <= {shreg[11:0], d_s2};
          if (fall) falls <= falls + 5'h01;
          if (push) begin
            sel_n <= 1'b1;
            state <= ST_GAP;
          end
        end
        ST_GAP: begin
          sclk <= 1'b0;
          if (div_tick) state <= ST_IDLE;
        end
      endcase
    end
  end
  assign link.sclk = sclk;
  assign link.select_shutdown_n = sel_n;
  // Two-entry result buffer.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      buf_d[0] <= 13'h0000;
      buf_d[1] <= 13'h0000;
    end else begin
      if (push) begin
        buf_d[wr_ptr] <= shreg;
        wr_ptr <= !wr_ptr;
      end
      if (pop) rd_ptr <= !rd_ptr;
      cnt <= cnt + 2'(push) - 2'(pop);
    end
  end
  // Outputs registered.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_res_valid <= 1'b0;
      o_res_data <= 13'h0000;
    end else begin
      o_busy <= (state != ST_IDLE);
      o_res_valid <= (cnt - 2'(pop) + 2'(push)) != 2'h0;
      o_res_data <= (cnt - 2'(pop) == 2'h0) ? shreg : buf_d[rd_ptr ^ pop];
    end
  end
endmodule : dsr_host

// File: dsr_device.sv
// Purpose: Converter end: acquires, converts and shifts a 13-bit result.
// Assumes: Runs on the link clock; sample arrives from i_clk domain.
// Notes: Sample word is held still while selected, so the link domain reads it as a static word.
module dsr_device
  import dsr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic signed [15:0] i_sample,
  input wire logic i_sample_stb,
  output logic o_standby,
  dsr_link_if.device link
);
  import dsr_pkg::*;
  logic [12:0] hold;
  logic [12:0] sar;
  logic [3:0] falls;
  logic sd_out;
  // Latch the clamped sample only in standby. A toggle synchroniser would need three link
  // clock edges, which the session does not give before the sign bit, so the word is
  // frozen instead while selected and the link side reads it as a quasi-static value.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold <= 13'h0000;
    end else if (i_sample_stb && o_standby) begin
      hold <= dsr_clamp(i_sample);
    end
  end
  // Sequencer on falling edges; select high resets it asynchronously.
  wire sess_rst_n = i_rst_n && !link.select_shutdown_n;
  always_ff @(negedge link.sclk or negedge sess_rst_n) begin
    if (!sess_rst_n) begin
      falls <= ZERO4;
      sar <= 13'h0000;
      sd_out <= 1'b0;
    end else begin
      if (falls != LAST_BIT + ACQ_FALLS) falls <= falls + 4'h1;
      if (falls == ACQ_FALLS - 4'h1) begin
        sar <= {hold[11:0], 1'b0};
        sd_out <= hold[12];
      end else if (falls >= ACQ_FALLS && falls < LAST_BIT + ACQ_FALLS) begin
        sd_out <= sar[12];
        sar <= {sar[11:0], 1'b0};
      end
    end
  end
  assign link.sdata = sd_out;
  assign link.sdata_oe_n = link.select_shutdown_n;
  // Standby flag into system domain.
  logic s1;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= 1'b1;
      o_standby <= 1'b1;
    end else begin
      s1 <= link.select_shutdown_n;
      o_standby <= s1;
    end
  end
endmodule : dsr_device

// File: dsr_monitor.sv
// Purpose: Link checks for the converter readout.
// Assumes: Link signals are sampled on the host clock.
// Notes: Serial clock falls are counted per session.
module dsr_monitor (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic sclk,
  input wire logic select_shutdown_n,
  input wire logic sdata,
  input wire logic sdata_oe_n
);
  logic sclk_q;
  logic [4:0] falls;
  wire fell_sclk = sclk_q & ~sclk;
  wire [4:0] next_falls = falls + {4'h0, fell_sclk};
  // The count restarts at each select so a short session shows up.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q <= 1'b0;
      falls <= 5'h00;
    end else begin
      sclk_q <= sclk;
      falls <= select_shutdown_n ? 5'h00 : next_falls;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence sess_open; $fell(select_shutdown_n); endsequence
  sequence sess_close; $rose(select_shutdown_n); endsequence
  fall_count_a: assert property (sess_close |-> next_falls == 5'h0f)
    else $error("session clock count wrong");
  change_fall_a: assert property ((!sdata_oe_n && $changed(sdata)) |-> !sclk)
    else $error("data moved while clock high");
  release_a: assert property (sess_close |-> ##[0:3] sdata_oe_n)
    else $error("data pin not released");
  idle_clock_a: assert property (select_shutdown_n [*2] |-> !sclk)
    else $error("clock runs outside a session");
  open_low_a: assert property (sess_open |-> !sclk)
    else $error("session opened with clock high");
  sess_len_a: assert property (sess_open |-> ##[100:200] select_shutdown_n)
    else $error("session not closed in time");
  msb_drive_a: assert property ((!select_shutdown_n && falls >= 5'h02) |-> !sdata_oe_n)
    else $error("data pin idle after acquisition");
  gap_high_a: assert property (sess_close |=> select_shutdown_n)
    else $error("select not held high between sessions");
endmodule : dsr_monitor

// File: testbench.sv
// Purpose: Self-checking bench joining host and converter ends.
// Assumes: The host makes the serial clock from clk.
// Notes: Samples are digital stand-ins for the analog input.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic stb = 1'b0;
  logic ready = 1'b0;
  logic signed [15:0] sample = 16'sh0000;
  logic busy, tmo, valid, standby;
  dsr_code_t data;
  int error_cnt = 0;
  int checks = 0;
  dsr_code_t want [6] = '{13'h0fff, 13'h1000, 13'h0001, 13'h1fff, 13'h0000, 13'h0abc};
  logic signed [15:0] ins [6] = '{16'sh7fff, 16'sh8000, 16'sh0001, 16'shffff, 16'sh0, 16'sh0abc};
  dsr_link_if link();
  dsr_host #(.MAX_CYC(2000)) dsr_host_i (.i_clk(clk), .i_rst_n(rst_n), .i_start(start),
    .o_busy(busy), .o_timeout(tmo), .o_res_data(data), .o_res_valid(valid),
    .i_res_ready(ready), .link(link.host));
  dsr_device dsr_device_i (.i_clk(clk), .i_rst_n(rst_n), .i_sample(sample),
    .i_sample_stb(stb), .o_standby(standby), .link(link.device));
  dsr_monitor dsr_monitor_i (.i_clk(clk), .i_rst_n(rst_n), .sclk(link.sclk),
    .select_shutdown_n(link.select_shutdown_n), .sdata(link.sdata),
    .sdata_oe_n(link.sdata_oe_n));
  always #5 clk = ~clk;
  // Bounded wait for a level, so a hang becomes a mismatch.
  task automatic hold(ref logic s, input logic v);
    for (int n = 0; n < 400 && s !== v; n++) @(posedge clk);
    #1;
    `CHK(s, v)
  endtask : hold
  // The sample is loaded only while idle, so it cannot leak into a running session.
  task automatic conv(input logic signed [15:0] v);
    hold(busy, 1'b0);
    sample = v;
    stb = 1'b1;
    @(posedge clk);
    #1;
    stb = 1'b0;
    start = 1'b1;
    hold(busy, 1'b1);
    start = 1'b0;
  endtask : conv
  // Take one word from the result buffer.
  task automatic take(input dsr_code_t w);
    hold(valid, 1'b1);
    `CHK(data, w)
    ready = 1'b1;
    @(posedge clk);
    #1;
    ready = 1'b0;
  endtask : take
  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK(standby, 1'b1)
    for (int i = 0; i < 6; i++) begin
      conv(ins[i]);
      take(want[i]);
    end
    // Two sessions with the consumer stalled fill the buffer.
    conv(ins[2]);
    repeat (20) @(posedge clk);
    `CHK(standby, 1'b0)
    conv(ins[3]);
    hold(busy, 1'b0);
    start = 1'b1;
    repeat (40) @(posedge clk);
    `CHK(busy, 1'b0)
    start = 1'b0;
    take(want[2]);
    take(want[3]);
    `CHK(tmo, 1'b0)
    `CHK(standby, 1'b1)
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule : testbench
